// file: rtl/pgt_pkg.sv
// Purpose: Shared constants for the pattern generator timing configuration block
// Assumes: 20 MHz register clock, byte-wide indirect register space
// Notes:   Offsets are indirect indices unless named as main-space addresses
package pgt_pkg;

  // ----------------------------------------------------------------
  // Main register space addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PGT_ADDR_INDEX = 8'h66;
  localparam logic [7:0] PGT_ADDR_DATA  = 8'h67;

  // ----------------------------------------------------------------
  // Indirect indices
  // ----------------------------------------------------------------
  localparam logic [7:0] PGT_IDX_CDIV    = 8'h03;
  localparam logic [7:0] PGT_IDX_TOT_WL  = 8'h04;
  localparam logic [7:0] PGT_IDX_TOT_MIX = 8'h05;
  localparam logic [7:0] PGT_IDX_TOT_HH  = 8'h06;
  localparam logic [7:0] PGT_IDX_ACT_WL  = 8'h07;
  localparam logic [7:0] PGT_IDX_ACT_MIX = 8'h08;
  localparam logic [7:0] PGT_IDX_ACT_HH  = 8'h09;
  localparam logic [7:0] PGT_IDX_HSW     = 8'h0a;
  localparam logic [7:0] PGT_IDX_CDIV2   = 8'h1a;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PGT_RST_CDIV    = 8'h08;
  localparam logic [7:0] PGT_RST_TOT_WL  = 8'h48;
  localparam logic [7:0] PGT_RST_TOT_MIX = 8'h53;
  localparam logic [7:0] PGT_RST_TOT_HH  = 8'h1e;
  localparam logic [7:0] PGT_RST_ACT_WL  = 8'h20;
  localparam logic [7:0] PGT_RST_ACT_MIX = 8'h03;
  localparam logic [7:0] PGT_RST_ACT_HH  = 8'h1e;
  localparam logic [7:0] PGT_RST_HSW     = 8'h0a;
  localparam logic [7:0] PGT_RST_CDIV2   = 8'h01;

  // ----------------------------------------------------------------
  // Field layout and divider figures
  // ----------------------------------------------------------------
  localparam int          PGT_CDIV_N_MSB = 6;
  localparam logic [7:0]  PGT_CDIV_MASK  = 8'h7f;
  localparam int          PGT_LOW_NIB    = 3;
  localparam int          PGT_HIGH_NIB   = 4;
  localparam int          PGT_BASE_MHZ   = 200;
  localparam int          PGT_MULT_MHZ   = 800;
  localparam int          PGT_CLK_MHZ    = 20;
  localparam int          PGT_CLK_PER_NS = 50;

endpackage

// file: rtl/pgt_pix_nco.sv
// Purpose: Pixel rate generator: phase accumulator yielding a scaled pixel tick
// Assumes: Register clock at PGT_CLK_MHZ; tick rate is pixel frequency / SCALE
// Notes:   Rates above the register clock saturate at one tick per cycle
`timescale 1ns/1ps
module pgt_pix_nco import pgt_pkg::*; #(
  parameter int SCALE = 100
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [6:0] div_n,
  input  wire logic [7:0] fac_m,
  output logic            pix_tick,
  output logic            pix_clk
);

  // ----------------------------------------------------------------
  // Rate terms
  // ----------------------------------------------------------------
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] acc_r;
  logic [31:0] sum;
  logic [31:0] rem;

  // Numerator in MHz: 200 for M of one, else 800*M (M of zero treated as one)
  always_comb begin
    if (fac_m > 8'h01) begin
      num = 32'(PGT_MULT_MHZ) * 32'(fac_m);
    end else begin
      num = 32'(PGT_BASE_MHZ);
    end
    den = 32'(div_n) * 32'(PGT_CLK_MHZ) * 32'(SCALE);
    sum = acc_r + num;
    rem = sum - den;
  end

  // Accumulate; a zero divisor stops the pixel clock rather than dividing by zero
  always_ff @(posedge clk) begin
    if (srst || div_n == 7'h00) begin
      acc_r    <= 32'h0000_0000;
      pix_tick <= 1'b0;
    end else if (sum >= den) begin
      acc_r    <= (rem >= den) ? 32'h0000_0000 : rem; // Saturated rate drops excess
      pix_tick <= 1'b1;
    end else begin
      acc_r    <= sum;
      pix_tick <= 1'b0;
    end
  end

  // Half-rate square wave for observation
  always_ff @(posedge clk) begin
    if (srst) begin
      pix_clk <= 1'b0;
    end else if (pix_tick) begin
      pix_clk <= ~pix_clk;
    end
  end

endmodule

// file: rtl/pgt_timing_cfg.sv
// Purpose: Internal timing configuration of a video test-pattern generator
// Assumes: Byte register port on clk; pg_enable comes from logic on clk
// Notes:   Settings reach the counters only while disabled or at frame end
`timescale 1ns/1ps
module pgt_timing_cfg import pgt_pkg::*; #(
  parameter int SCALE = 100
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        pg_enable,
  output logic      [6:0]  pixel_clock_divisor_n,
  output logic      [7:0]  pixel_clock_factor_m,
  output logic             pix_tick,
  output logic             pix_clk,
  output logic      [11:0] total_line_pixels,
  output logic      [11:0] total_frame_lines,
  output logic      [11:0] active_line_pixels,
  output logic      [11:0] active_frame_lines,
  output logic      [7:0]  hsync_pulse_pixels,
  output logic      [11:0] h_count,
  output logic      [11:0] v_count,
  output logic             hsync,
  output logic             data_active,
  output logic             frame_start
);

  // ----------------------------------------------------------------
  // Indirect register storage
  // ----------------------------------------------------------------
  logic [7:0] index_r;
  logic [7:0] pixel_clock_divisor_r;
  logic [7:0] total_width_low_r;
  logic [7:0] total_size_mixed_r;
  logic [7:0] total_height_high_r;
  logic [7:0] active_width_low_r;
  logic [7:0] active_size_mixed_r;
  logic [7:0] active_height_high_r;
  logic [7:0] hsync_pulse_width_r;
  logic [7:0] second_divider_config_r;
  logic       wr_data;
  logic       wr_index;

  assign wr_index = reg_wr && (reg_addr == PGT_ADDR_INDEX);
  assign wr_data  = reg_wr && (reg_addr == PGT_ADDR_DATA);

  // Index register: selects which indirect byte the data port reaches
  always_ff @(posedge clk) begin
    if (srst) begin
      index_r <= 8'h00;
    end else if (wr_index) begin
      index_r <= reg_wdata;
    end
  end

  // Indirect writes; unlisted indices are reserved and ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      pixel_clock_divisor_r   <= PGT_RST_CDIV;
      total_width_low_r       <= PGT_RST_TOT_WL;
      total_size_mixed_r      <= PGT_RST_TOT_MIX;
      total_height_high_r     <= PGT_RST_TOT_HH;
      active_width_low_r      <= PGT_RST_ACT_WL;
      active_size_mixed_r     <= PGT_RST_ACT_MIX;
      active_height_high_r    <= PGT_RST_ACT_HH;
      hsync_pulse_width_r     <= PGT_RST_HSW;
      second_divider_config_r <= PGT_RST_CDIV2;
    end else if (wr_data) begin
      case (index_r)
        PGT_IDX_CDIV: begin
          pixel_clock_divisor_r <= reg_wdata & PGT_CDIV_MASK; // Bit 7 reserved
        end
        PGT_IDX_TOT_WL: begin
          total_width_low_r <= reg_wdata;
        end
        PGT_IDX_TOT_MIX: begin
          total_size_mixed_r <= reg_wdata;
        end
        PGT_IDX_TOT_HH: begin
          total_height_high_r <= reg_wdata;
        end
        PGT_IDX_ACT_WL: begin
          active_width_low_r <= reg_wdata;
        end
        PGT_IDX_ACT_MIX: begin
          active_size_mixed_r <= reg_wdata;
        end
        PGT_IDX_ACT_HH: begin
          active_height_high_r <= reg_wdata;
        end
        PGT_IDX_HSW: begin
          hsync_pulse_width_r <= reg_wdata;
        end
        PGT_IDX_CDIV2: begin
          second_divider_config_r <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  // Data register reflects the indexed byte; reserved indices read zero
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == PGT_ADDR_INDEX) begin
      rd_mux = index_r;
    end else if (reg_addr == PGT_ADDR_DATA) begin
      case (index_r)
        PGT_IDX_CDIV:    rd_mux = pixel_clock_divisor_r;
        PGT_IDX_TOT_WL:  rd_mux = total_width_low_r;
        PGT_IDX_TOT_MIX: rd_mux = total_size_mixed_r;
        PGT_IDX_TOT_HH:  rd_mux = total_height_high_r;
        PGT_IDX_ACT_WL:  rd_mux = active_width_low_r;
        PGT_IDX_ACT_MIX: rd_mux = active_size_mixed_r;
        PGT_IDX_ACT_HH:  rd_mux = active_height_high_r;
        PGT_IDX_HSW:     rd_mux = hsync_pulse_width_r;
        PGT_IDX_CDIV2:   rd_mux = second_divider_config_r;
        default:         rd_mux = 8'h00;
      endcase
    end
  end

  // Read data is captured on the strobe and held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Field assembly from the byte registers
  // ----------------------------------------------------------------
  logic [11:0] tot_w;
  logic [11:0] tot_h;
  logic [11:0] act_w;
  logic [11:0] act_h;

  assign tot_w = {total_size_mixed_r[PGT_LOW_NIB:0], total_width_low_r};
  assign tot_h = {total_height_high_r, total_size_mixed_r[7:PGT_HIGH_NIB]};
  assign act_w = {active_size_mixed_r[PGT_LOW_NIB:0], active_width_low_r};
  assign act_h = {active_height_high_r, active_size_mixed_r[7:PGT_HIGH_NIB]};

  // ----------------------------------------------------------------
  // Applied settings
  // ----------------------------------------------------------------
  logic frame_end;
  logic apply;

  // Mid-frame edits would tear the picture, so they wait for the frame boundary
  assign apply = !pg_enable || frame_end;

  always_ff @(posedge clk) begin
    if (srst) begin
      pixel_clock_divisor_n <= PGT_RST_CDIV[PGT_CDIV_N_MSB:0];
      pixel_clock_factor_m  <= PGT_RST_CDIV2;
      total_line_pixels     <= {PGT_RST_TOT_MIX[PGT_LOW_NIB:0], PGT_RST_TOT_WL};
      total_frame_lines     <= {PGT_RST_TOT_HH, PGT_RST_TOT_MIX[7:PGT_HIGH_NIB]};
      active_line_pixels    <= {PGT_RST_ACT_MIX[PGT_LOW_NIB:0], PGT_RST_ACT_WL};
      active_frame_lines    <= {PGT_RST_ACT_HH, PGT_RST_ACT_MIX[7:PGT_HIGH_NIB]};
      hsync_pulse_pixels    <= PGT_RST_HSW;
    end else if (apply) begin
      pixel_clock_divisor_n <= pixel_clock_divisor_r[PGT_CDIV_N_MSB:0];
      pixel_clock_factor_m  <= second_divider_config_r;
      total_line_pixels     <= tot_w;
      total_frame_lines     <= tot_h;
      active_line_pixels    <= act_w;
      active_frame_lines    <= act_h;
      hsync_pulse_pixels    <= hsync_pulse_width_r;
    end
  end

  // ----------------------------------------------------------------
  // Pixel clock
  // ----------------------------------------------------------------
  pgt_pix_nco #(
    .SCALE (SCALE)
  ) u_nco (
    .clk      (clk),
    .srst     (srst),
    .div_n    (pixel_clock_divisor_n),
    .fac_m    (pixel_clock_factor_m),
    .pix_tick (pix_tick),
    .pix_clk  (pix_clk)
  );

  // ----------------------------------------------------------------
  // Timing counters
  // ----------------------------------------------------------------
  logic [11:0] h_last;
  logic [11:0] v_last;
  logic        h_wrap;

  // A total of zero wraps to the full 4096 count instead of locking up
  assign h_last    = total_line_pixels - 12'h001;
  assign v_last    = total_frame_lines - 12'h001;
  assign h_wrap    = pix_tick && (h_count == h_last);
  assign frame_end = pg_enable && h_wrap && (v_count == v_last);

  // Pixel counter along the line
  always_ff @(posedge clk) begin
    if (srst || !pg_enable) begin
      h_count <= 12'h000;
    end else if (h_wrap) begin
      h_count <= 12'h000;
    end else if (pix_tick) begin
      h_count <= h_count + 12'h001;
    end
  end

  // Line counter down the frame
  always_ff @(posedge clk) begin
    if (srst || !pg_enable) begin
      v_count <= 12'h000;
    end else if (frame_end) begin
      v_count <= 12'h000;
    end else if (h_wrap) begin
      v_count <= v_count + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Sync, blanking and frame marker
  // ----------------------------------------------------------------
  logic [12:0] hs_end;

  // Sync sits at the start of horizontal blanking; a width of zero gives no pulse
  assign hs_end = {1'b0, active_line_pixels} + {5'h00, hsync_pulse_pixels};

  always_ff @(posedge clk) begin
    if (srst || !pg_enable) begin
      hsync       <= 1'b0;
      data_active <= 1'b0;
    end else begin
      hsync       <= (h_count >= active_line_pixels) && ({1'b0, h_count} < hs_end);
      data_active <= (h_count < active_line_pixels) && (v_count < active_frame_lines);
    end
  end

  // One-cycle marker when the counters restart at the top of a frame
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_start <= 1'b0;
    end else begin
      frame_start <= frame_end;
    end
  end

endmodule

// file: verif/pgt_timing_cfg_properties.sv
// Purpose: Port-level checks of the timing configuration block
// Assumes: One clock domain, srst synchronous active high
// Notes:   Guards on past reset keep checks quiet after a mid-run reset
`timescale 1ns/1ps
module pgt_timing_cfg_chk import pgt_pkg::*; #(
  parameter int SCALE = 100
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        pg_enable,
  input wire logic [6:0]  pixel_clock_divisor_n,
  input wire logic [7:0]  pixel_clock_factor_m,
  input wire logic        pix_tick,
  input wire logic        pix_clk,
  input wire logic [11:0] total_line_pixels,
  input wire logic [11:0] total_frame_lines,
  input wire logic [11:0] active_line_pixels,
  input wire logic [11:0] active_frame_lines,
  input wire logic [7:0]  hsync_pulse_pixels,
  input wire logic [11:0] h_count,
  input wire logic [11:0] v_count,
  input wire logic        hsync,
  input wire logic        data_active,
  input wire logic        frame_start
);
  logic fe;
  // ------
  // Final tick of a frame
  // ------
  assign fe = pg_enable && pix_tick && (h_count == total_line_pixels - 12'h001)
    && (v_count == total_frame_lines - 12'h001);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Both flags are forced low while the generator is off, whatever the counters show
  a_hsync_window: assert property (!$past(srst) |-> hsync ==
    ($past(pg_enable) && {1'b0, $past(h_count)} >= {1'b0, $past(active_line_pixels)}
    && {1'b0, $past(h_count)}
    < {1'b0, $past(active_line_pixels)} + {5'h00, $past(hsync_pulse_pixels)}))
    else $error("hsync window wrong");
  a_active_region: assert property (!$past(srst) |-> data_active ==
    ($past(pg_enable) && $past(h_count) < $past(active_line_pixels)
    && $past(v_count) < $past(active_frame_lines)))
    else $error("active flag wrong");
  a_count_held: assert property (!pg_enable |=> h_count == 12'h000 && v_count == 12'h000)
    else $error("counters not held");
  a_pixel_step: assert property (pix_tick && pg_enable && !fe
    && h_count != total_line_pixels - 12'h001 |=> h_count == $past(h_count) + 12'h001)
    else $error("pixel step wrong");
  a_idle_stable: assert property (pg_enable && !pix_tick |=> $stable({h_count, v_count}))
    else $error("counter moved");
  a_apply_frozen: assert property (pg_enable && !fe |=> $stable({pixel_clock_divisor_n,
    pixel_clock_factor_m, total_line_pixels, total_frame_lines, active_line_pixels,
    active_frame_lines, hsync_pulse_pixels})) else $error("setting applied mid frame");
  a_frame_pulse: assert property (!$past(srst) |-> frame_start == $past(fe))
    else $error("frame pulse wrong");
  a_pix_clk_toggle: assert property (!$past(srst) |-> pix_clk == ($past(pix_clk) ^ $past(pix_tick)))
    else $error("pixel clock toggle wrong");
  c_frame: cover property (frame_start);
  c_hsync: cover property ($rose(hsync));
  c_read: cover property (reg_rd && reg_addr == PGT_ADDR_DATA);
endmodule
bind pgt_timing_cfg pgt_timing_cfg_chk #(.SCALE(SCALE)) u_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pg_enable(pg_enable), .pixel_clock_divisor_n(pixel_clock_divisor_n),
  .pixel_clock_factor_m(pixel_clock_factor_m), .pix_tick(pix_tick), .pix_clk(pix_clk),
  .total_line_pixels(total_line_pixels), .total_frame_lines(total_frame_lines),
  .active_line_pixels(active_line_pixels), .active_frame_lines(active_frame_lines),
  .hsync_pulse_pixels(hsync_pulse_pixels), .h_count(h_count), .v_count(v_count),
  .hsync(hsync), .data_active(data_active), .frame_start(frame_start));

// file: verif/tb_pgt_timing_cfg.sv
// Purpose: Register and timing bench for the configuration block
// Assumes: SCALE of 1 so frames stay short
// Notes:   Event counters sample at rising edges, waits on the counters use falling edges
`timescale 1ns/1ps
module tb_pgt_timing_cfg import pgt_pkg::*;;
  localparam int SCALE = 1;
  logic        clk, srst, wr, rd, en, tk, pc, hs, act, fs;
  logic [7:0]  adr, wd, rdat, hsw, m;
  logic [6:0]  n;
  logic [11:0] tw, th, aw, ah, hc, vc;
  logic [7:0]  ix [9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h1a};
  logic [7:0]  rv [9] = '{8'h08, 8'h48, 8'h53, 8'h1e, 8'h20, 8'h03, 8'h1e, 8'h0a, 8'h01};
  logic [7:0]  wv [9] = '{8'hff, 8'ha5, 8'hc7, 8'h3b, 8'h5a, 8'hd2, 8'h1e, 8'h7e, 8'h02};
  logic [7:0]  sv [7] = '{8'h08, 8'h40, 8'h00, 8'h04, 8'h30, 8'h00, 8'h02};
  int          n_errors = 0, n_checks = 0, cyc = 0, nt = 0, nf = 0, nh = 0, na = 0, e;

  pgt_timing_cfg #(.SCALE(SCALE)) dut (.clk(clk), .srst(srst), .reg_addr(adr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .pg_enable(en),
    .pixel_clock_divisor_n(n), .pixel_clock_factor_m(m), .pix_tick(tk), .pix_clk(pc),
    .total_line_pixels(tw), .total_frame_lines(th), .active_line_pixels(aw),
    .active_frame_lines(ah), .hsync_pulse_pixels(hsw), .h_count(hc), .v_count(vc),
    .hsync(hs), .data_active(act), .frame_start(fs));

  // ------
  // Clock, hang guard and event counters
  // ------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    nt += (tk === 1'b1);
    nf += (fs === 1'b1);
    nh += (tk === 1'b1 && hs === 1'b1);
    na += (tk === 1'b1 && act === 1'b1);
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end

  task automatic chk(input logic [11:0] g, input logic [11:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  // One-cycle write strobe; caller gets back control after the taking edge
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= 1'b1;
    @(posedge clk);
    wr  <= 1'b0;
  endtask
  task automatic wi(input logic [7:0] i, input logic [7:0] d);
    put(PGT_ADDR_INDEX, i);
    put(PGT_ADDR_DATA, d);
  endtask
  // Read data lands on the taking edge, so look just after it
  task automatic rm(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    adr <= a;
    rd  <= 1'b1;
    @(posedge clk);
    rd  <= 1'b0;
    #1 chk({4'h0, rdat}, {4'h0, x});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    srst = 1'b1;
    {wr, rd, en, adr, wd} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    chk({5'h00, n}, 12'h008);
    chk({4'h0, m}, 12'h001);
    chk({4'h0, hsw}, 12'h00a);
    chk({4'h0, rdat}, 12'h000);
    chk(tw, 12'h348);
    chk(th, 12'h1e5);
    chk(aw, 12'h320);
    chk(ah, 12'h1e0);
    for (int i = 0; i < 9; i++) begin
      put(PGT_ADDR_INDEX, ix[i]);
      rm(PGT_ADDR_DATA, rv[i]);
    end
    for (int i = 0; i < 9; i++) wi(ix[i], wv[i]);
    for (int i = 0; i < 9; i++) begin
      put(PGT_ADDR_INDEX, ix[i]);
      rm(PGT_ADDR_DATA, i == 0 ? 8'h7f : wv[i]);
    end
    chk({5'h00, n}, 12'h07f);
    chk({4'h0, m}, 12'h002);
    chk(tw, 12'h7a5);
    chk(th, 12'h3bc);
    chk(aw, 12'h25a);
    chk(ah, 12'h1ed);
    chk({4'h0, hsw}, 12'h07e);
    wi(8'h20, 8'h55);
    rm(PGT_ADDR_DATA, 8'h00);
    rm(PGT_ADDR_INDEX, 8'h20);
    rm(8'h10, 8'h00);
    // Tick rate for M of one and above, within one tick of the ideal
    for (int k = 1; k < 4; k++) begin
      wi(PGT_IDX_CDIV2, 8'(k));
      // Skip the edge still run on the old factor; clearing off the edge avoids a race
      repeat (2) @(negedge clk);
      nt = 0;
      repeat (1000) @(negedge clk);
      e = (k > 1 ? PGT_MULT_MHZ * k : PGT_BASE_MHZ) * 1000 / (127 * PGT_CLK_MHZ * SCALE);
      n_checks++;
      if (nt < e - 1 || nt > e + 1) begin
        n_errors++;
        $display("BAD %0t tick count %0d near %0d", $time, nt, e);
      end
    end
    for (int i = 1; i < 8; i++) wi(ix[i], sv[i-1]);
    wi(PGT_IDX_CDIV2, 8'h01);
    @(posedge clk);
    en <= 1'b1;
    wi(PGT_IDX_HSW, 8'h03);
    #1 chk({4'h0, hsw}, 12'h002);
    nf = 0;
    while (nf == 0) @(negedge clk);
    chk({4'h0, hsw}, 12'h003);
    {nt, nh, nf, na} = '0;
    while (nf == 0) @(negedge clk);
    chk(nt[11:0], 12'd32);
    chk(nh[11:0], 12'd12);
    chk(na[11:0], 12'd12);
    complete_run;
  end
endmodule
